// >>> pmm_map.svh
/*
 * Constants for the power mode manager: field positions, reset values
 * and timing counts. Assumes inclusion by bare name from design files.
 */
`ifndef PMM_MAP_SVH
`define PMM_MAP_SVH

// ----------------------------------------------------------------------
// clock generation control word fields
// ----------------------------------------------------------------------
`define PMM_CG_SLOW_EN      0
`define PMM_CG_PLL_OFF      1
`define PMM_CG_PRESC        2
`define PMM_CG_DIV_LSB      3
`define PMM_CG_DIV_MSB      7
`define PMM_CG_RTC_RUN      8
`define PMM_CG_PROGRAMMABLE_FREQUENCY_OUTPUT_EN      9
`define PMM_CG_RESET        16'h0000

// ----------------------------------------------------------------------
// peripheral disable word fields
// ----------------------------------------------------------------------
`define PMM_PD_GROUP        15
`define PMM_PD_RESET        16'h0000
`define PMM_PD_GROUP_MASK   15'h00FF

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PMM_CLK_NS          50
`define PMM_RTC_TICK_NS     1000000
`define PMM_RTC_TICK_CYC    (`PMM_RTC_TICK_NS / `PMM_CLK_NS)

`endif

// >>> pmm_pkg.sv
/*
 * Types shared by the power mode manager files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pmm_pkg;
    // ------------------------------------------------------------------
    // power mode states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PMM_RUN   = 2'b00,
        PMM_IDLE  = 2'b01,
        PMM_SLEEP = 2'b10,
        PMM_PDOWN = 2'b11
    } pmm_mode_t;

    // instruction codes presented by the core
    typedef enum logic [1:0] {
        PMM_INS_NONE  = 2'b00,
        PMM_INS_IDLE  = 2'b01,
        PMM_INS_SLEEP = 2'b10,
        PMM_INS_PDOWN = 2'b11
    } pmm_instr_t;
endpackage

// >>> pmm_sync3.sv
/*
 * Three-stage input synchroniser; output changes once stages two and
 * three agree. Assumes a single clock with enable and async reset.
 */
`timescale 1ns/10ps
`default_nettype none
module pmm_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic CLK,
    input  wire logic NRST,
    input  wire logic CE,
    input  wire logic D,
    output var  logic Q
);
    logic s1;
    logic s2;
    logic s3;

    // ------------------------------------------------------------------
    // sampling chain; s1 only feeds s2 to keep metastability contained
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            Q  <= RST_VAL;
        end else if (CE) begin
            s1 <= D;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                Q <= s3;
            end
        end
    end
endmodule // pmm_sync3
`default_nettype wire

// >>> pmm_power_mode_manager.sv
/*
 * Power mode manager top: instruction-entered idle, sleep and power
 * down, slow-down clock divide with PLL bypass, programmable frequency
 * output, per-peripheral and group disables, RTC periodic wakeup.
 * Assumes the core presents a one-cycle instruction strobe and writes
 * the control words through plain load strobes on the same clock.
 */
// Functional notes
// - modes entered only by dedicated instructions
// - idle stops core clock, peripherals run
// - sleep/power down stop all; RTC optional
// - external interrupt ends sleep
// - power down only when NMI pin low
// - clock control register steers clock distribution
// - slow-down divides by 1..32, doubled prescaled
// - PLL may be disabled in slow-down
// - programmable frequency output pin
// - each peripheral disabled individually
// - one group bit disables many peripherals
// - RTC periodically wakes from sleep
// - mechanisms operate concurrently
`timescale 1ns/10ps
`default_nettype none
`include "pmm_map.svh"
module pmm_power_mode_manager #(
    parameter int NPER        = 15,
    parameter int RTC_TICK    = `PMM_RTC_TICK_CYC,
    parameter int PROGRAMMABLE_FREQUENCY_OUTPUT_W      = 16
) (
    input  wire logic              CLK,
    input  wire logic              NRST,
    input  wire logic              CE,
    input  wire pmm_pkg::pmm_instr_t INSTR,
    input  wire logic              INSTR_VALID,
    input  wire logic              NMI_PIN,
    input  wire logic              EXT_IRQ_PIN,
    input  wire logic              IRQ_PENDING,
    input  wire logic              CG_WR,
    input  wire logic [15:0]       CG_WDATA,
    input  wire logic              PD_WR,
    input  wire logic [15:0]       PD_WDATA,
    input  wire logic              PROGRAMMABLE_FREQUENCY_OUTPUT_WR,
    input  wire logic [PROGRAMMABLE_FREQUENCY_OUTPUT_W-1:0] PROGRAMMABLE_FREQUENCY_OUTPUT_RELOAD,
    output var  pmm_pkg::pmm_mode_t MODE,
    output var  logic [15:0]       CLOCK_GENERATION_CONTROL_REG,
    output var  logic [15:0]       PERIPHERAL_DISABLE_CONTROL_REG,
    output logic                   CPU_CLK_EN,
    output logic                   PER_CLK_EN,
    output logic [NPER-1:0]        PER_CLK_GATE_EN,
    output logic                   RTC_CLK_EN,
    output logic                   PLL_EN,
    output var  logic              PROGRAMMABLE_FREQUENCY_OUTPUT,
    output var  logic              RTC_WAKE
);
    import pmm_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic nmi_s;
    logic ext_irq_s;

    pmm_sync3 #(.RST_VAL(1'b1)) u_sync_nmi (
        .CLK  (CLK),
        .NRST (NRST),
        .CE   (CE),
        .D    (NMI_PIN),
        .Q    (nmi_s)
    );

    pmm_sync3 #(.RST_VAL(1'b0)) u_sync_irq (
        .CLK  (CLK),
        .NRST (NRST),
        .CE   (CE),
        .D    (EXT_IRQ_PIN),
        .Q    (ext_irq_s)
    );

    // ------------------------------------------------------------------
    // decoded control fields
    // ------------------------------------------------------------------
    wire       slow_en  = CLOCK_GENERATION_CONTROL_REG[`PMM_CG_SLOW_EN];
    wire       pll_off  = CLOCK_GENERATION_CONTROL_REG[`PMM_CG_PLL_OFF];
    wire       presc    = CLOCK_GENERATION_CONTROL_REG[`PMM_CG_PRESC];
    wire [4:0] div_fld  =
        CLOCK_GENERATION_CONTROL_REG[`PMM_CG_DIV_MSB:`PMM_CG_DIV_LSB];
    wire       rtc_run  = CLOCK_GENERATION_CONTROL_REG[`PMM_CG_RTC_RUN];
    wire       programmable_frequency_output_en  = CLOCK_GENERATION_CONTROL_REG[`PMM_CG_PROGRAMMABLE_FREQUENCY_OUTPUT_EN];
    wire       grp_off  =
        PERIPHERAL_DISABLE_CONTROL_REG[`PMM_PD_GROUP];
    wire [14:0] grp_mask = grp_off ? `PMM_PD_GROUP_MASK : 15'h0000;

    // ------------------------------------------------------------------
    // control words; only the strobes load them, never mode entry
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CLOCK_GENERATION_CONTROL_REG   <= `PMM_CG_RESET;
            PERIPHERAL_DISABLE_CONTROL_REG <= `PMM_PD_RESET;
        end else if (CE) begin
            if (CG_WR) begin
                CLOCK_GENERATION_CONTROL_REG <= CG_WDATA;
            end
            if (PD_WR) begin
                PERIPHERAL_DISABLE_CONTROL_REG <= PD_WDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // RTC wakeup tick; keeps counting in sleep when allowed
    // ------------------------------------------------------------------
    logic [31:0] rtc_cnt;
    wire rtc_live = (MODE == PMM_RUN) || (MODE == PMM_IDLE) || rtc_run;
    wire rtc_end  = rtc_cnt == 32'(RTC_TICK - 1);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rtc_cnt  <= 32'h0000_0000;
            RTC_WAKE <= 1'b0;
        end else if (CE) begin
            RTC_WAKE <= 1'b0;
            if (rtc_live) begin
                rtc_cnt <= rtc_end ? 32'h0000_0000 : rtc_cnt + 32'h1;
                RTC_WAKE <= rtc_end;
            end
        end
    end

    // ------------------------------------------------------------------
    // power mode state machine
    // ------------------------------------------------------------------
    pmm_mode_t next_mode;
    wire ins = INSTR_VALID && (MODE == PMM_RUN);

    always_comb begin
        next_mode = MODE;
        case (MODE)
            PMM_RUN: begin
                if (ins && INSTR == PMM_INS_IDLE) begin
                    next_mode = PMM_IDLE;
                end else if (ins && INSTR == PMM_INS_SLEEP) begin
                    next_mode = PMM_SLEEP;
                end else if (ins && INSTR == PMM_INS_PDOWN && !nmi_s) begin
                    next_mode = PMM_PDOWN;
                end
            end
            PMM_IDLE: begin
                if (IRQ_PENDING || ext_irq_s) begin
                    next_mode = PMM_RUN;
                end
            end
            PMM_SLEEP: begin
                if (ext_irq_s || RTC_WAKE) begin
                    next_mode = PMM_RUN;
                end
            end
            PMM_PDOWN: begin
                next_mode = PMM_PDOWN; // only reset leaves power down
            end
            default: begin
                next_mode = PMM_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            MODE <= PMM_RUN;
        end else if (CE) begin
            MODE <= next_mode;
        end
    end

    // ------------------------------------------------------------------
    // slow-down divider: ratio 1..32, doubled under prescaler
    // ------------------------------------------------------------------
    logic [5:0] div_cnt;
    wire  [5:0] div_ratio = {1'b0, div_fld} + 6'h01;
    wire  [5:0] div_top   = presc ? 6'((div_ratio << 1) - 6'h01)
                                  : 6'(div_ratio - 6'h01);
    wire        div_tick  = !slow_en || (div_cnt == div_top);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            div_cnt <= 6'h00;
        end else if (CE) begin
            div_cnt <= div_tick ? 6'h00 : div_cnt + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // clock gate enables; modes, slow-down and disables combine freely
    // ------------------------------------------------------------------
    wire run_core = MODE == PMM_RUN;
    wire run_per  = (MODE == PMM_RUN) || (MODE == PMM_IDLE);

    assign CPU_CLK_EN = run_core && div_tick;
    assign PER_CLK_EN = run_per;
    assign PER_CLK_GATE_EN = {NPER{run_per}}
        & ~(PERIPHERAL_DISABLE_CONTROL_REG[NPER-1:0] | grp_mask);
    assign RTC_CLK_EN = run_per || rtc_run;
    assign PLL_EN = run_per && !(slow_en && pll_off);

    // ------------------------------------------------------------------
    // frequency output: toggles every reload+1 cycles, stopped in sleep
    // ------------------------------------------------------------------
    logic [PROGRAMMABLE_FREQUENCY_OUTPUT_W-1:0] programmable_frequency_output_reload;
    logic [PROGRAMMABLE_FREQUENCY_OUTPUT_W-1:0] programmable_frequency_output_cnt;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            programmable_frequency_output_reload <= '0;
            programmable_frequency_output_cnt    <= '0;
            PROGRAMMABLE_FREQUENCY_OUTPUT <= 1'b0;
        end else if (CE) begin
            if (PROGRAMMABLE_FREQUENCY_OUTPUT_WR) begin
                programmable_frequency_output_reload <= PROGRAMMABLE_FREQUENCY_OUTPUT_RELOAD;
            end
            if (!programmable_frequency_output_en || !run_per) begin
                programmable_frequency_output_cnt <= '0;
                PROGRAMMABLE_FREQUENCY_OUTPUT <= 1'b0;
            end else if (programmable_frequency_output_cnt == programmable_frequency_output_reload) begin
                programmable_frequency_output_cnt <= '0;
                PROGRAMMABLE_FREQUENCY_OUTPUT <=
                    !PROGRAMMABLE_FREQUENCY_OUTPUT;
            end else begin
                programmable_frequency_output_cnt <= programmable_frequency_output_cnt + PROGRAMMABLE_FREQUENCY_OUTPUT_W'(1);
            end
        end
    end
endmodule // pmm_power_mode_manager
`default_nettype wire

// >>> pmm_core_model.sv
/* Core model: issues mode-entry instructions as one-cycle strobes.
   Assumes the caller starts each instruction just after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module pmm_core_model (
    input  wire logic                CLK,
    output var  pmm_pkg::pmm_instr_t INSTR,
    output var  logic                INSTR_VALID
);
    import pmm_pkg::*;
    initial begin
        INSTR = PMM_INS_NONE;
        INSTR_VALID = 1'b0;
    end
    // code is inverted once released so a stale value never looks valid
    task automatic exec(input pmm_instr_t code);
        @(posedge CLK);
        #1;
        INSTR = code;
        INSTR_VALID = 1'b1;
        @(posedge CLK);
        #1;
        INSTR = pmm_instr_t'(~code);
        INSTR_VALID = 1'b0;
    endtask
endmodule // pmm_core_model
`default_nettype wire

// >>> pmm_power_mode_manager_asserts.sv
/* Checker for the power mode manager ports.
   Assumes it is bound to the top module and CLK is the only clock. */
`timescale 1ns/10ps
`default_nettype none
`include "pmm_map.svh"
module pmm_power_mode_manager_asserts #(parameter int NPER = 15) (
    input wire logic                CLK,
    input wire logic                NRST,
    input wire logic                CE,
    input wire pmm_pkg::pmm_instr_t INSTR,
    input wire logic                INSTR_VALID,
    input wire logic                NMI_PIN,
    input wire logic                IRQ_PENDING,
    input wire logic                CG_WR,
    input wire logic [15:0]         CG_WDATA,
    input wire pmm_pkg::pmm_mode_t  MODE,
    input wire logic [15:0]         CLOCK_GENERATION_CONTROL_REG,
    input wire logic [15:0]         PERIPHERAL_DISABLE_CONTROL_REG,
    input wire logic                CPU_CLK_EN,
    input wire logic                PER_CLK_EN,
    input wire logic [NPER-1:0]     PER_CLK_GATE_EN,
    input wire logic                RTC_CLK_EN,
    input wire logic                PLL_EN,
    input wire logic                RTC_WAKE
);
    import pmm_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic [15:0] cg;
    logic [15:0] pd;
    logic [14:0] grp;
    // group bit widens the individual disables
    assign cg = CLOCK_GENERATION_CONTROL_REG;
    assign pd = PERIPHERAL_DISABLE_CONTROL_REG;
    assign grp = pd[15] ? `PMM_PD_GROUP_MASK : 15'h0000;
    // six samples high leave margin for the pin synchroniser
    sequence nmi_high_pdown_s;
        NMI_PIN[*6] ##0 (CE && INSTR_VALID && INSTR == PMM_INS_PDOWN
            && MODE == PMM_RUN);
    endsequence
    mode_entry_a: assert property (
        $past(MODE) == PMM_RUN && MODE != PMM_RUN |-> $past(INSTR_VALID))
        else $error("mode left run unbidden");
    idle_clocks_a: assert property (
        MODE == PMM_IDLE |-> !CPU_CLK_EN && PER_CLK_EN)
        else $error("idle clocks wrong");
    stop_clocks_a: assert property (
        MODE inside {PMM_SLEEP, PMM_PDOWN}
        |-> !CPU_CLK_EN && !PER_CLK_EN && !PLL_EN && RTC_CLK_EN == cg[8])
        else $error("stopped mode clocks wrong");
    pdown_guard_a: assert property (
        nmi_high_pdown_s |=> MODE == PMM_RUN)
        else $error("power down taken with nmi high");
    cg_load_a: assert property (
        CE && CG_WR |=> cg == $past(CG_WDATA))
        else $error("clock word not loaded");
    full_speed_a: assert property (
        MODE == PMM_RUN && !cg[0] |-> CPU_CLK_EN)
        else $error("core clock divided");
    pll_bypass_a: assert property (
        PLL_EN == (MODE inside {PMM_RUN, PMM_IDLE} && !(cg[0] && cg[1])))
        else $error("pll enable wrong");
    per_gate_a: assert property (
        PER_CLK_GATE_EN == ({NPER{PER_CLK_EN}}
        & ~(pd[NPER-1:0] | grp[NPER-1:0])))
        else $error("gates wrong");
    idle_wake_a: assert property (
        CE && MODE == PMM_IDLE && IRQ_PENDING |=> MODE == PMM_RUN)
        else $error("idle not left");
    rtc_wake_a: assert property (
        CE && MODE == PMM_SLEEP && RTC_WAKE |-> ##[1:2] MODE == PMM_RUN)
        else $error("rtc did not wake");
endmodule // pmm_power_mode_manager_asserts
bind pmm_power_mode_manager pmm_power_mode_manager_asserts #(.NPER(NPER)) u_chk (
    .CLK(CLK), .NRST(NRST), .CE(CE), .INSTR(INSTR),
    .INSTR_VALID(INSTR_VALID), .NMI_PIN(NMI_PIN), .IRQ_PENDING(IRQ_PENDING),
    .CG_WR(CG_WR), .CG_WDATA(CG_WDATA), .MODE(MODE),
    .CLOCK_GENERATION_CONTROL_REG(CLOCK_GENERATION_CONTROL_REG),
    .PERIPHERAL_DISABLE_CONTROL_REG(PERIPHERAL_DISABLE_CONTROL_REG),
    .CPU_CLK_EN(CPU_CLK_EN), .PER_CLK_EN(PER_CLK_EN),
    .PER_CLK_GATE_EN(PER_CLK_GATE_EN), .RTC_CLK_EN(RTC_CLK_EN),
    .PLL_EN(PLL_EN), .RTC_WAKE(RTC_WAKE));
`default_nettype wire

// >>> tb.sv
/* Self-checking bench for the power mode manager with a core model.
   Assumes pmm_pkg, the map header and the core model compile first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pmm_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, nmi = 1'b1, ext = 1'b0, irq = 1'b0;
    logic        ce = 1'b1;
    logic [2:0]  we = 3'h0;
    logic [15:0] wd = 16'h0000, cg_reg, pd_reg;
    logic [14:0] gate;
    logic        cpu_en, per_en, rtc_en, pll_en, programmable_frequency_output, rtc_wake, ivld;
    pmm_instr_t  instr;
    pmm_mode_t   mode;
    int          n_fail = 0, checked = 0;
    pmm_core_model core (.CLK(clk), .INSTR(instr), .INSTR_VALID(ivld));
    pmm_power_mode_manager #(.RTC_TICK(8)) dut (
        .CLK(clk), .NRST(nrst), .CE(ce), .INSTR(instr), .INSTR_VALID(ivld),
        .NMI_PIN(nmi), .EXT_IRQ_PIN(ext), .IRQ_PENDING(irq),
        .CG_WR(we[0]), .CG_WDATA(wd), .PD_WR(we[1]), .PD_WDATA(wd),
        .PROGRAMMABLE_FREQUENCY_OUTPUT_WR(we[2]), .PROGRAMMABLE_FREQUENCY_OUTPUT_RELOAD(wd), .MODE(mode),
        .CLOCK_GENERATION_CONTROL_REG(cg_reg),
        .PERIPHERAL_DISABLE_CONTROL_REG(pd_reg), .CPU_CLK_EN(cpu_en),
        .PER_CLK_EN(per_en), .PER_CLK_GATE_EN(gate), .RTC_CLK_EN(rtc_en),
        .PLL_EN(pll_en), .PROGRAMMABLE_FREQUENCY_OUTPUT(programmable_frequency_output),
        .RTC_WAKE(rtc_wake));
    // 50 ns clock
    initial forever #25 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle load strobe: 0 clock word, 1 disable word, 2 reload;
    // a gap cycle keeps back-to-back strobes from touching
    task automatic wr(input int k, input logic [15:0] d);
        we[k] = 1'b1;
        wd = d;
        tick(1);
        we[k] = 1'b0;
        tick(1);
    endtask
    // windows are whole periods, so the count does not hang on phase
    task automatic t_slow();
        logic [15:0] cfg [4] = '{16'h001B, 16'h001D, 16'h00F9, 16'h0002};
        int ex [4] = '{16, 8, 2, 64};
        int c;
        for (int i = 0; i < 4; i++) begin
            wr(0, cfg[i]);
            chk("clock word", cfg[i], cg_reg);
            tick(40);
            c = 0;
            repeat (64) begin
                c += int'(cpu_en === 1'b1);
                tick(1);
            end
            chk("core ticks", 16'(ex[i]), 16'(c));
            chk("pll", {15'h0000, i != 0}, pll_en);
        end
        chk("mode", PMM_RUN, mode);
    endtask
    task automatic t_idle();
        core.exec(PMM_INS_IDLE);
        chk("idle clocks", 16'h0005, {mode, cpu_en, per_en});
        wr(1, 16'h0005);
        chk("gates", 16'h7FFA, gate);
        wr(1, 16'h8000);
        chk("gates", 16'h7F00, gate);
        wr(1, 16'h0000);
        irq = 1'b1;
        tick(2);
        irq = 1'b0;
        chk("mode", PMM_RUN, mode);
    endtask
    task automatic t_sleep(input logic [15:0] cw);
        int n;
        wr(0, cw);
        for (n = 0; n < 12 && rtc_wake !== 1'b1; n++) tick(1);
        chk("rtc wake", 16'h0001, rtc_wake);
        core.exec(PMM_INS_SLEEP);
        chk("sleep", 16'h0008, {mode, cpu_en, per_en});
        chk("pll", 16'h0000, pll_en);
        chk("rtc clock", cw[8], rtc_en);
        core.exec(PMM_INS_IDLE);
        for (n = 0; n < 20 && mode !== PMM_RUN; n++) tick(1);
        if (!cw[8]) begin
            chk("mode", PMM_SLEEP, mode);
            ext = 1'b1;
            tick(8);
            ext = 1'b0;
        end
        chk("mode", PMM_RUN, mode);
        tick(8);
    endtask
    task automatic t_pdown();
        wr(0, 16'h001B);
        wr(1, 16'h8005);
        core.exec(PMM_INS_PDOWN);
        chk("mode", PMM_RUN, mode);
        nmi = 1'b0;
        tick(6);
        core.exec(PMM_INS_PDOWN);
        chk("mode", PMM_PDOWN, mode);
        {irq, ext} = 2'h3;
        tick(10);
        chk("mode", PMM_PDOWN, mode);
        {irq, ext, nrst} = 3'h0;
        tick(1);
        chk("reset words", 16'h0000, cg_reg | pd_reg);
        chk("mode", PMM_RUN, mode);
        {nrst, nmi} = 2'h3;
        tick(2);
        chk("mode", PMM_RUN, mode);
    endtask
    task automatic t_programmable_frequency_output();
        logic p;
        int c = 0;
        wr(2, 16'h0003);
        wr(0, 16'h0200);
        tick(12);
        p = programmable_frequency_output;
        repeat (32) begin
            tick(1);
            c += int'(programmable_frequency_output !== p);
            p = programmable_frequency_output;
        end
        chk("programmable_frequency_output edges", 16'h0008, 16'(c));
        // clock enable low must freeze the running output
        ce = 1'b0;
        p = programmable_frequency_output;
        tick(6);
        chk("programmable_frequency_output frozen", {15'h0000, p}, programmable_frequency_output);
        ce = 1'b1;
        wr(0, 16'h0000);
        tick(2);
        chk("programmable_frequency_output off", 16'h0000, programmable_frequency_output);
    endtask
    task automatic test_done();
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        tick(10);
        nrst = 1'b1;
        tick(2);
        t_slow();
        t_idle();
        t_sleep(16'h0000);
        t_sleep(16'h0100);
        t_programmable_frequency_output();
        t_pdown();
        test_done();
    end
    // run needs about 600 cycles; 8000 means a hang
    initial begin
        #400000;
        n_fail++;
        test_done();
    end
endmodule // tb
`default_nettype wire
